// >>> hw/bdd_init_seq.sv
// table initialisation sequencer run after every fabric reset
`timescale 1ns/1ps
`default_nettype none
module bdd_init_seq
    import bdd_pkg::*;
#(
    parameter int ENTRIES = INIT_ENTRIES
)(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic fabric_rst,
    output var  logic ready
);

    localparam int CW = $clog2(ENTRIES + 1);
    localparam logic [CW-1:0] LAST = CW'(ENTRIES - 1);

    bdd_init_e     state_ff;
    bdd_init_e     nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    // ------------------------------------------------------------------
    // count through ENTRIES entries without touching the table, then flag ready
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            BDD_INIT_RUN: begin
                if (cnt_ff == LAST) begin
                    nxt_state = BDD_INIT_DONE;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
            BDD_INIT_DONE: begin
                nxt_state = BDD_INIT_DONE;
            end
            default: begin
                nxt_state = BDD_INIT_RUN;
            end
        endcase
        if (fabric_rst) begin
            nxt_state = BDD_INIT_RUN;
            nxt_cnt   = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= BDD_INIT_RUN;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign ready = (state_ff == BDD_INIT_DONE);

endmodule : bdd_init_seq
`default_nettype wire

// >>> hw/bdd_pkg.sv
// constants and types shared by the buffer drop / discard table block
package bdd_pkg;

    // ------------------------------------------------------------------
    // bus and data widths
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 32;
    localparam int IDX_W   = 4;
    localparam int PROB_W  = 10;
    localparam int USAGE_W = 8;
    localparam int TBL_DEPTH = 16;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_DROP_CNT   = 16'h1c07;
    localparam logic [ADDR_W-1:0] IDX_READY_STS  = 16'h1c08;
    localparam logic [ADDR_W-1:0] IDX_TBL_CMD    = 16'h1c09;
    localparam logic [ADDR_W-1:0] IDX_TBL_WDATA  = 16'h1c0a;
    localparam logic [ADDR_W-1:0] IDX_TBL_RDATA  = 16'h1c0b;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 16'h1c20;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK   = 16'h1c21;

    localparam logic [ADDR_W-1:0] ADR_DROP_CNT   = IDX_DROP_CNT   << 2;
    localparam logic [ADDR_W-1:0] ADR_READY_STS  = IDX_READY_STS  << 2;
    localparam logic [ADDR_W-1:0] ADR_TBL_CMD    = IDX_TBL_CMD    << 2;
    localparam logic [ADDR_W-1:0] ADR_TBL_WDATA  = IDX_TBL_WDATA  << 2;
    localparam logic [ADDR_W-1:0] ADR_TBL_RDATA  = IDX_TBL_RDATA  << 2;
    localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MASK   = IDX_IRQ_MASK   << 2;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CMD_DIR_BIT = 4;
    localparam int CMD_IDX_LSB = 0;
    localparam int CMD_W       = 5;
    localparam int READY_BIT   = 0;
    localparam logic [CMD_W-1:0]  CMD_RST   = 5'h00;
    localparam logic [PROB_W-1:0] PROB_RST  = 10'h000;
    localparam logic [DATA_W-1:0] CNT_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CNT_MAX   = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] CNT_ONE   = 32'h0000_0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // interrupt status / mask bits
    localparam int IRQ_W     = 3;
    localparam int IRQ_READY = 0;
    localparam int IRQ_SAT   = 1;
    localparam int IRQ_CMD   = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // table initialisation length after a fabric reset
    localparam int INIT_ENTRIES = 512;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BDD_INIT_RUN  = 2'b00,
        BDD_INIT_DONE = 2'b01
    } bdd_init_e;

endpackage : bdd_pkg

// >>> hw/bdd_regs.sv
// register bank: port 2 drop counter, table ready flag, discard table
`timescale 1ns/1ps
`default_nettype none
module bdd_regs
    import bdd_pkg::*;
#(
    parameter int INIT_LEN = INIT_ENTRIES
)(
    input  wire logic               CLOCK,
    input  wire logic               RST_B,
    input  wire logic               FABRIC_RST,
    input  wire logic [ADDR_W-1:0]  ADDRESS,
    input  wire logic               READ,
    input  wire logic               WRITE,
    input  wire logic [DATA_W-1:0]  WRITEDATA,
    input  wire logic [3:0]         BYTEENABLE,
    output var  logic [DATA_W-1:0]  READDATA,
    output var  logic               WAITREQUEST,
    output var  logic               IRQ,
    input  wire logic               DROP_NO_SPACE,
    input  wire logic               DROP_RED,
    input  wire logic               DROP_YELLOW,
    input  wire logic [USAGE_W-1:0] BUF_USAGE,
    output var  logic [PROB_W-1:0]  DROP_PROB,
    output var  logic               TABLES_READY
);

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------
    bdd_tbl_if tbl_if ();
    logic init_ready;

    bdd_tables u_tables (
        .clk   (CLOCK),
        .rst_b (RST_B),
        .tbl   (tbl_if.tbl)
    );

    bdd_init_seq #(
        .ENTRIES (INIT_LEN)
    ) u_init (
        .clk        (CLOCK),
        .rst_b      (RST_B),
        .fabric_rst (FABRIC_RST),
        .ready      (init_ready)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic              wait_ff,     nxt_wait;
    logic [DATA_W-1:0] rdata_bus_ff, nxt_rdata_bus;
    logic [DATA_W-1:0] cnt_ff,      nxt_cnt;
    logic [CMD_W-1:0]  cmd_ff,      nxt_cmd;
    logic [PROB_W-1:0] wdata_ff,    nxt_wdata;
    logic [PROB_W-1:0] tbl_rd_ff,   nxt_tbl_rd;
    logic [IRQ_W-1:0]  irq_sts_ff,  nxt_irq_sts;
    logic [IRQ_W-1:0]  irq_msk_ff,  nxt_irq_msk;
    logic              irq_ff,      nxt_irq;
    logic              ready_q_ff,  nxt_ready_q;
    logic [PROB_W-1:0] prob_ff,     nxt_prob;

    // ------------------------------------------------------------------
    // bus handshake: request latched on first edge, answered on second
    // ------------------------------------------------------------------
    logic              req;
    logic              latch;
    logic              wr_acc;
    logic [DATA_W-1:0] be_mask;
    logic              sel_cnt;
    logic              sel_rdy;
    logic              sel_cmd;
    logic              sel_wd;
    logic              sel_rd;
    logic              sel_ist;
    logic              sel_imk;
    logic [DATA_W-1:0] rd_mux;

    assign req    = READ | WRITE;
    assign latch  = req & wait_ff;
    assign wr_acc = WRITE & ~wait_ff;

    assign sel_cnt = (ADDRESS == ADR_DROP_CNT);
    assign sel_rdy = (ADDRESS == ADR_READY_STS);
    assign sel_cmd = (ADDRESS == ADR_TBL_CMD);
    assign sel_wd  = (ADDRESS == ADR_TBL_WDATA);
    assign sel_rd  = (ADDRESS == ADR_TBL_RDATA);
    assign sel_ist = (ADDRESS == ADR_IRQ_STATUS);
    assign sel_imk = (ADDRESS == ADR_IRQ_MASK);

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_be
            assign be_mask[gb*8 +: 8] = {8{BYTEENABLE[gb]}};
        end
    endgenerate

    always_comb begin
        rd_mux = DATA_ZERO;
        if (sel_cnt) begin
            rd_mux = cnt_ff;
        end else if (sel_rdy) begin
            rd_mux[READY_BIT] = init_ready;
        end else if (sel_cmd) begin
            rd_mux[CMD_W-1:0] = cmd_ff;
        end else if (sel_wd) begin
            rd_mux[PROB_W-1:0] = wdata_ff;
        end else if (sel_rd) begin
            rd_mux[PROB_W-1:0] = tbl_rd_ff;
        end else if (sel_ist) begin
            rd_mux[IRQ_W-1:0] = irq_sts_ff;
        end else if (sel_imk) begin
            rd_mux[IRQ_W-1:0] = irq_msk_ff;
        end
    end

    always_comb begin
        nxt_wait      = ~latch;
        nxt_rdata_bus = rdata_bus_ff;
        if (latch && READ) begin
            nxt_rdata_bus = rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // port 2 drop counter
    // ------------------------------------------------------------------
    logic drop_evt;
    logic cnt_clr;
    logic sat_evt;

    assign drop_evt = DROP_NO_SPACE | DROP_RED | DROP_YELLOW;
    assign cnt_clr  = (latch & READ & sel_cnt) | FABRIC_RST;

    always_comb begin
        nxt_cnt = cnt_ff;
        sat_evt = 1'b0;
        if (cnt_clr) begin
            nxt_cnt = drop_evt ? CNT_ONE : CNT_RST;
        end else if (drop_evt && cnt_ff != CNT_MAX) begin
            nxt_cnt = cnt_ff + CNT_ONE;
            sat_evt = (cnt_ff == CNT_MAX - CNT_ONE);
        end
    end

    // ------------------------------------------------------------------
    // discard table command, write data and read data
    // ------------------------------------------------------------------
    logic              cmd_go;
    logic [CMD_W-1:0]  cmd_new;
    logic [DATA_W-1:0] wd_merge;

    assign cmd_go   = wr_acc & sel_cmd & BYTEENABLE[0];
    assign cmd_new  = WRITEDATA[CMD_W-1:0];
    assign wd_merge = ({{(DATA_W-PROB_W){1'b0}}, wdata_ff} & ~be_mask)
                    | (WRITEDATA & be_mask);

    always_comb begin
        nxt_cmd    = cmd_ff;
        nxt_wdata  = wdata_ff;
        nxt_tbl_rd = tbl_rd_ff;
        if (cmd_go) begin
            nxt_cmd = cmd_new;
            if (cmd_new[CMD_DIR_BIT]) begin
                nxt_tbl_rd = tbl_if.rd_data;
            end
        end
        if (wr_acc && sel_wd) begin
            nxt_wdata = wd_merge[PROB_W-1:0];
        end
        if (FABRIC_RST) begin
            nxt_cmd = CMD_RST;
        end
    end

    assign tbl_if.wr_en   = cmd_go & ~cmd_new[CMD_DIR_BIT];
    assign tbl_if.idx     = cmd_new[CMD_IDX_LSB +: IDX_W];
    assign tbl_if.wr_data = wdata_ff;
    assign tbl_if.usage   = BUF_USAGE;

    // ------------------------------------------------------------------
    // applied yellow drop probability for current usage
    // ------------------------------------------------------------------
    always_comb begin
        nxt_prob = tbl_if.prob;
    end

    // ------------------------------------------------------------------
    // interrupts: sticky, write one to clear, set beats clear
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_w1c;

    assign irq_evt[IRQ_READY] = init_ready & ~ready_q_ff;
    assign irq_evt[IRQ_SAT]   = sat_evt;
    assign irq_evt[IRQ_CMD]   = cmd_go;
    assign irq_w1c = (wr_acc && sel_ist && BYTEENABLE[0])
                   ? WRITEDATA[IRQ_W-1:0] : IRQ_RST;

    always_comb begin
        nxt_ready_q = init_ready;
        nxt_irq_sts = (irq_sts_ff & ~irq_w1c) | irq_evt;
        nxt_irq_msk = irq_msk_ff;
        if (wr_acc && sel_imk && BYTEENABLE[0]) begin
            nxt_irq_msk = WRITEDATA[IRQ_W-1:0];
        end
        nxt_irq = |(irq_sts_ff & irq_msk_ff);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wait_ff      <= 1'b1;
            rdata_bus_ff <= DATA_ZERO;
            cnt_ff       <= CNT_RST;
            cmd_ff       <= CMD_RST;
            wdata_ff     <= PROB_RST;
            tbl_rd_ff    <= PROB_RST;
            irq_sts_ff   <= IRQ_RST;
            irq_msk_ff   <= IRQ_RST;
            irq_ff       <= 1'b0;
            ready_q_ff   <= 1'b0;
            prob_ff      <= PROB_RST;
        end else begin
            wait_ff      <= nxt_wait;
            rdata_bus_ff <= nxt_rdata_bus;
            cnt_ff       <= nxt_cnt;
            cmd_ff       <= nxt_cmd;
            wdata_ff     <= nxt_wdata;
            tbl_rd_ff    <= nxt_tbl_rd;
            irq_sts_ff   <= nxt_irq_sts;
            irq_msk_ff   <= nxt_irq_msk;
            irq_ff       <= nxt_irq;
            ready_q_ff   <= nxt_ready_q;
            prob_ff      <= nxt_prob;
        end
    end

    assign READDATA     = rdata_bus_ff;
    assign WAITREQUEST  = wait_ff;
    assign IRQ          = irq_ff;
    assign DROP_PROB    = prob_ff;
    assign TABLES_READY = ready_q_ff;

endmodule : bdd_regs
`default_nettype wire

// >>> hw/bdd_tables.sv
// sixteen-entry random discard probability table with usage lookup
`timescale 1ns/1ps
`default_nettype none
module bdd_tables
    import bdd_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    bdd_tbl_if.tbl    tbl
);

    // ------------------------------------------------------------------
    // storage, one register per entry
    // ------------------------------------------------------------------
    logic [PROB_W-1:0] entry_ff  [TBL_DEPTH];
    logic [PROB_W-1:0] nxt_entry [TBL_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < TBL_DEPTH; gi++) begin : g_entry
            always_comb begin
                nxt_entry[gi] = entry_ff[gi];
                if (tbl.wr_en && tbl.idx == IDX_W'(gi)) begin
                    nxt_entry[gi] = tbl.wr_data;
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    entry_ff[gi] <= PROB_RST;
                end else begin
                    entry_ff[gi] <= nxt_entry[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // usage to index: finer steps at low usage
    // ------------------------------------------------------------------
    function automatic logic [IDX_W-1:0] usage_idx(
        input logic [USAGE_W-1:0] u
    );
        logic [IDX_W-1:0] r;
        if (u[7:6] == 2'b00) begin
            r = {1'b0, u[5:3]};
        end else if (u[7] == 1'b0) begin
            r = {2'b10, u[5:4]};
        end else begin
            r = {2'b11, u[6:5]};
        end
        return r;
    endfunction : usage_idx

    assign tbl.rd_data = entry_ff[tbl.idx];
    assign tbl.prob    = entry_ff[usage_idx(tbl.usage)];

endmodule : bdd_tables
`default_nettype wire

// >>> hw/bdd_tbl_if.sv
// link between the register block and the discard probability table
`timescale 1ns/1ps
`default_nettype none
interface bdd_tbl_if;
    import bdd_pkg::*;

    logic                 wr_en;
    logic [IDX_W-1:0]     idx;
    logic [PROB_W-1:0]    wr_data;
    logic [PROB_W-1:0]    rd_data;
    logic [USAGE_W-1:0]   usage;
    logic [PROB_W-1:0]    prob;

    modport ctl (
        output wr_en,
        output idx,
        output wr_data,
        output usage,
        input  rd_data,
        input  prob
    );
    modport tbl (
        input  wr_en,
        input  idx,
        input  wr_data,
        input  usage,
        output rd_data,
        output prob
    );
endinterface : bdd_tbl_if
`default_nettype wire

// >>> test/bdd_regs_asserts.sv
// concurrent checks on the buffer drop / discard table register block
`timescale 1ns/1ps
`default_nettype none
module bdd_regs_asserts
    import bdd_pkg::*;
#(
    parameter int INIT_LEN = INIT_ENTRIES
)(
    input wire logic               CLOCK,
    input wire logic               RST_B,
    input wire logic               FABRIC_RST,
    input wire logic [ADDR_W-1:0]  ADDRESS,
    input wire logic               READ,
    input wire logic               WRITE,
    input wire logic [DATA_W-1:0]  WRITEDATA,
    input wire logic [3:0]         BYTEENABLE,
    input wire logic [DATA_W-1:0]  READDATA,
    input wire logic               WAITREQUEST,
    input wire logic               IRQ,
    input wire logic               DROP_NO_SPACE,
    input wire logic               DROP_RED,
    input wire logic               DROP_YELLOW,
    input wire logic [USAGE_W-1:0] BUF_USAGE,
    input wire logic [PROB_W-1:0]  DROP_PROB,
    input wire logic               TABLES_READY
);
    // latest edge at which ready may rise after a fabric reset
    localparam int RISE_MAX = INIT_LEN + 4;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    sequence bus_req;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence quiet_tbl;
        !WRITE && $stable(BUF_USAGE);
    endsequence
    sequence fab_clear;
        TABLES_READY && !FABRIC_RST && !$past(FABRIC_RST);
    endsequence

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    wait_one_cycle_a: assert property (
        bus_req |=> !WAITREQUEST ##1 WAITREQUEST)
        else $error("wait state is not exactly one cycle");
    no_idle_ack_a: assert property (
        !(READ || WRITE) && WAITREQUEST |=> WAITREQUEST)
        else $error("acknowledge without a request");
    rdata_hold_a: assert property (
        !(READ && WAITREQUEST) |=> $stable(READDATA))
        else $error("read data moved without a read");
    ready_drop_a: assert property (
        FABRIC_RST |-> ##3 !TABLES_READY)
        else $error("ready flag kept through fabric reset");
    ready_wait_a: assert property (
        $fell(FABRIC_RST) |-> ##2 !TABLES_READY [*4])
        else $error("ready flag set before initialisation");
    ready_rise_a: assert property (
        $fell(FABRIC_RST) |-> ##[1:RISE_MAX] TABLES_READY)
        else $error("ready flag never set after fabric reset");
    ready_keep_a: assert property (
        fab_clear |=> TABLES_READY)
        else $error("ready flag dropped without fabric reset");
    prob_steady_a: assert property (
        quiet_tbl [*4] |=> $stable(DROP_PROB))
        else $error("drop probability moved with usage steady");
endmodule : bdd_regs_asserts
bind bdd_regs bdd_regs_asserts #(.INIT_LEN(INIT_LEN)) i_chk (
    .CLOCK(CLOCK), .RST_B(RST_B), .FABRIC_RST(FABRIC_RST),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .IRQ(IRQ),
    .DROP_NO_SPACE(DROP_NO_SPACE), .DROP_RED(DROP_RED),
    .DROP_YELLOW(DROP_YELLOW), .BUF_USAGE(BUF_USAGE),
    .DROP_PROB(DROP_PROB), .TABLES_READY(TABLES_READY));
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the buffer drop / discard table register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bdd_pkg::*;
    localparam int INIT_LEN = 8;
    logic               clock, rst_b, fabric_rst, read, write, irq;
    logic               waitrequest, tables_ready;
    logic [ADDR_W-1:0]  address;
    logic [DATA_W-1:0]  writedata, readdata;
    logic [3:0]         byteenable;
    logic [2:0]         drops;
    logic [USAGE_W-1:0] buf_usage;
    logic [PROB_W-1:0]  drop_prob;
    int                 err_total, checks_done, cyc;

    bdd_regs #(.INIT_LEN(INIT_LEN)) i_dut (
        .CLOCK(clock), .RST_B(rst_b), .FABRIC_RST(fabric_rst),
        .ADDRESS(address), .READ(read), .WRITE(write),
        .WRITEDATA(writedata), .BYTEENABLE(byteenable),
        .READDATA(readdata), .WAITREQUEST(waitrequest), .IRQ(irq),
        .DROP_NO_SPACE(drops[2]), .DROP_RED(drops[1]),
        .DROP_YELLOW(drops[0]), .BUF_USAGE(buf_usage),
        .DROP_PROB(drop_prob), .TABLES_READY(tables_ready));

    always #2 clock = ~clock;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic test_done;
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic rd, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
        int n;
        n = 0;
        @(posedge clock);
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0);
        chk("wait edges", 32'h2, 32'(n));
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd_chk

    task automatic wait_ready;
        int n;
        n = 0;
        while (tables_ready !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        chk("tables ready", 32'h1, {31'h0, tables_ready});
    endtask : wait_ready

    task automatic drop(input logic [2:0] m);
        @(posedge clock);
        drops <= m;
        @(posedge clock);
        drops <= 3'h0;
    endtask : drop

    function automatic logic [31:0] prob(input int i);
        return {22'h0, PROB_W'(i * 61 + 3)};
    endfunction : prob

    function automatic logic [7:0] lo(input int i);
        if (i < 8) return 8'(i * 8);
        if (i < 12) return 8'(64 + (i - 8) * 16);
        return 8'(128 + (i - 12) * 32);
    endfunction : lo

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clock = 0; rst_b = 0; fabric_rst = 0; read = 0; write = 0;
        address = '0; writedata = '0; byteenable = 4'hf; drops = '0;
        buf_usage = '0; err_total = 0; checks_done = 0; cyc = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rd_chk("ready reg", ADR_READY_STS, 32'h0);
        rd_chk("drop count", ADR_DROP_CNT, CNT_RST);
        rd_chk("command", ADR_TBL_CMD, 32'h0);
        rd_chk("read data", ADR_TBL_RDATA, 32'h0);
        rd_chk("unmapped", 16'h7ffc, 32'h0);
        wait_ready();
        rd_chk("ready reg", ADR_READY_STS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        // one packet per drop cycle, whatever the cause
        drop(3'b100);
        drop(3'b010);
        drop(3'b001);
        drop(3'b111);
        rd_chk("drop count", ADR_DROP_CNT, 32'h4);
        rd_chk("drop count", ADR_DROP_CNT, 32'h0);
        // fill the table, then read every entry back
        for (int i = 0; i < 16; i++) begin
            wr(ADR_TBL_WDATA, prob(i));
            wr(ADR_TBL_CMD, 32'(i));
        end
        for (int i = 0; i < 16; i++) begin
            wr(ADR_TBL_CMD, 32'(16 + i));
            rd_chk("command", ADR_TBL_CMD, 32'(16 + i));
            rd_chk("read data", ADR_TBL_RDATA, prob(i));
            rd_chk("read data", ADR_TBL_RDATA, prob(i));
        end
        // both ends of every usage range
        for (int i = 0; i < 16; i++) begin
            for (int j = 0; j < 2; j++) begin
                buf_usage <= j == 0 ? lo(i) : (i == 15 ? 8'hff
                                               : lo(i + 1) - 8'h1);
                repeat (3) @(posedge clock);
                chk("drop prob", prob(i), {22'h0, drop_prob});
            end
        end
        wr(ADR_TBL_WDATA, 32'hffff_ffff);
        rd_chk("write data", ADR_TBL_WDATA, 32'h0000_03ff);
        // interrupt: ready rose and commands done are pending
        rd_chk("irq status", ADR_IRQ_STATUS, 32'h5);
        wr(ADR_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clock);
        chk("irq", 32'h1, {31'h0, irq});
        wr(ADR_IRQ_STATUS, 32'h5);
        repeat (3) @(posedge clock);
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("irq status", ADR_IRQ_STATUS, 32'h0);
        // fabric reset reruns initialisation, table survives
        drop(3'b001);
        @(posedge clock);
        fabric_rst <= 1'b1;
        @(posedge clock);
        fabric_rst <= 1'b0;
        rd_chk("ready reg", ADR_READY_STS, 32'h0);
        rd_chk("drop count", ADR_DROP_CNT, 32'h0);
        rd_chk("command", ADR_TBL_CMD, 32'h0);
        wait_ready();
        repeat (3) @(posedge clock);
        chk("irq", 32'h1, {31'h0, irq});
        chk("drop prob", prob(15), {22'h0, drop_prob});
        test_done();
    end
endmodule : testbench
`default_nettype wire
